// *** rtl/tcm_pkg.sv ***
// Constants and types for the ternary code error monitor
package tcm_pkg;
    // Register geometry
    localparam int        SR_STAGES  = 5;
    localparam int        SR_TOP     = SR_STAGES - 1;  // stage five
    localparam int        SR_BOT     = 0;              // stage one
    localparam logic [4:0] SR_RST    = 5'h00;          // all zeros after reset
    localparam int        SR_VALID_N = 6;              // thermometer values

    // Clock
    localparam int CLK_PERIOD_PS = 8000;               // 125 MHz

    // Fast error pulse width, least figure rounds up
    localparam int ERR_FAST_MIN_PS = 4250;
    localparam int ERR_FAST_MAX_PS = 5250;
    localparam int ERR_FAST_CYC_RAW = (ERR_FAST_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ERR_FAST_CYC = (ERR_FAST_CYC_RAW < 1) ? 1 : ERR_FAST_CYC_RAW;

    // Stretched error pulse, typical figure, bounded by least and longest
    localparam int STR_MIN_NS = 500;
    localparam int STR_TYP_NS = 700;
    localparam int STR_MAX_NS = 2000;
    localparam int STR_MIN_CYC = (STR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STR_MAX_CYC = (STR_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int STR_TYP_CYC = (STR_TYP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STR_W       = 8;

    // Symbol rate limits, kbaud
    localparam int RATE_SLOW_KBAUD = 25500;
    localparam int RATE_FAST_KBAUD = 105000;
    localparam int RATE_BIT_NUM    = 4;                // bit rate = 4/3 symbol rate
    localparam int RATE_BIT_DEN    = 3;

    // Input pulse fail timeout, time without any pulse of one polarity
    localparam int FAIL_TIME_NS = 10000;
    localparam int FAIL_CYC     = (FAIL_TIME_NS * 1000) / CLK_PERIOD_PS;

    // Stretcher states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_HOLD
    } str_state_t;
endpackage

// *** rtl/tcm_in_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module tcm_in_sync (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst_n,     // Async reset, active low
    input  wire logic async_in,  // Comparator indication from the pin
    output logic      level_r    // Filtered level in clk_sys domain
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_nxt;

    // Level only moves once stages two and three agree
    always_comb begin
        level_nxt = level_r;
        if (s2_r == s3_r) begin
            level_nxt = s3_r;
        end
    end

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r    <= async_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end
endmodule

// *** rtl/tcm_monitor.sv ***
// Ternary code error monitor: running-sum register, error and fail outputs
`timescale 1ns/100ps
module tcm_monitor
    import tcm_pkg::*;
#(
    parameter int FAIL_CYCLES    = FAIL_CYC,        // Cycles without pulses before fail
    parameter int RATE_KBAUD     = RATE_FAST_KBAUD, // Rated symbol rate of this variant
    parameter int STRETCH_CYCLES = STR_TYP_CYC      // Stretched pulse length
) (
    input  wire logic       clk_sys,      // 125 MHz system clock
    input  wire logic       rst_n,        // Async reset, active low
    input  wire logic       pos_ind,      // Positive comparator, high above threshold
    input  wire logic       neg_ind,      // Negative comparator, high below threshold
    output logic            err_fast_n,   // Fast error pulse, active low
    output logic            err_stretch,  // Stretched error pulse, active high
    output logic            pos_fail,     // No positive pulses seen in timeout
    output logic            neg_fail,     // No negative pulses seen in timeout
    output logic            rate_err,     // Symbol spacing under rated period, pulse
    output logic [4:0]      dsum,         // Running-sum register, bit 0 is stage one
    output logic            dsum_valid    // Register holds a thermometer value
);
    // Symbol period in cycles at the rated rate; the longest figure rounds down
    localparam int SYM_PS      = 1000000000 / RATE_KBAUD;
    localparam int SYM_CYC_RAW = SYM_PS / CLK_PERIOD_PS;
    localparam int SYM_CYC     = (SYM_CYC_RAW < 1) ? 1 : SYM_CYC_RAW;
    localparam int GAP_W       = 4;
    localparam int FAIL_W      = $clog2(FAIL_CYCLES + 1);

    // True when the pattern is one of the six thermometer codes
    function automatic logic is_thermo(input logic [4:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 1; i < SR_STAGES; i++) begin
            if (v[i] && !v[i-1]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // Saturating count toward a limit, shared by both fail timers
    function automatic logic [FAIL_W-1:0] fail_step(input logic [FAIL_W-1:0] c,
                                                    input logic              clr);
        logic [FAIL_W-1:0] n;
        n = c;
        if (clr) begin
            n = '0;
        end else if (c != FAIL_W'(FAIL_CYCLES)) begin
            n = c + FAIL_W'(1);
        end
        return n;
    endfunction

    // Input capture
    // Comparator levels come from the line receiver, outside clk_sys;
    // a glitch shorter than one cycle never reaches the level
    logic pos_lvl;
    logic neg_lvl;

    // Comparator outputs are asynchronous to clk_sys
    tcm_in_sync u_pos_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (pos_ind),
        .level_r  (pos_lvl)
    );

    tcm_in_sync u_neg_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (neg_ind),
        .level_r  (neg_lvl)
    );

    // Symbol classification
    // Both polarities are taken at the falling end of the indication,
    // so a long pulse still counts as one symbol
    logic pos_q_r;
    logic neg_q_r;
    logic pos_q_nxt;
    logic neg_q_nxt;
    logic pos_end;
    logic neg_end;
    logic pos_sym;
    logic neg_sym;
    logic any_sym;

    // A symbol is taken at the end of its indication
    always_comb begin
        pos_q_nxt = pos_lvl;
        neg_q_nxt = neg_lvl;
        pos_end   = pos_q_r && !pos_lvl;
        neg_end   = neg_q_r && !neg_lvl;
        // Both ending together is not a legal symbol; treated as zero level
        pos_sym   = pos_end && !neg_end;
        neg_sym   = neg_end && !pos_end;
        any_sym   = pos_end || neg_end;
    end

    // Previous filtered levels for the end detectors
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_q_r <= 1'b0;
            neg_q_r <= 1'b0;
        end else begin
            pos_q_r <= pos_q_nxt;
            neg_q_r <= neg_q_nxt;
        end
    end

    // Running-sum register and error detect
    // Thermometer of five stages: positive fills from stage one upward,
    // negative drains it from stage five downward
    logic [4:0] sr_r;
    logic [4:0] sr_nxt;
    logic       err_evt;
    logic       valid_r;
    logic       valid_nxt;

    // Reset value is only a convenience: any start pattern is flushed by
    // five symbols of one polarity, so logic never relies on it
    always_comb begin
        sr_nxt  = sr_r;
        err_evt = 1'b0;
        if (pos_sym) begin
            err_evt = sr_r[SR_TOP];
            sr_nxt  = {sr_r[SR_TOP-1:0], 1'b1};
        end else if (neg_sym) begin
            err_evt = !sr_r[SR_BOT];
            sr_nxt  = {1'b0, sr_r[SR_TOP:1]};
        end
        valid_nxt = is_thermo(sr_nxt);
    end

    // Flag is registered with the register so both change on one edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sr_r    <= SR_RST;
            valid_r <= 1'b1;
        end else begin
            sr_r    <= sr_nxt;
            valid_r <= valid_nxt;
        end
    end

    // Fast error pulse
    // The pin figure is a few ns, below one clock; one cycle is the
    // closest this clock can offer, so downstream sees a wider pulse
    logic [1:0] fast_cnt_r;
    logic [1:0] fast_cnt_nxt;
    logic       fast_n_r;
    logic       fast_n_nxt;

    // One clock is the shortest legal width; a new error restarts it
    always_comb begin
        fast_cnt_nxt = fast_cnt_r;
        fast_n_nxt   = 1'b1;
        if (err_evt) begin
            fast_cnt_nxt = 2'(ERR_FAST_CYC - 1);
            fast_n_nxt   = 1'b0;
        end else if (fast_cnt_r != 2'h0) begin
            fast_cnt_nxt = fast_cnt_r - 2'h1;
            fast_n_nxt   = 1'b0;
        end
    end

    // Idle high after reset, so no false error at release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fast_cnt_r <= 2'h0;
            fast_n_r   <= 1'b1;
        end else begin
            fast_cnt_r <= fast_cnt_nxt;
            fast_n_r   <= fast_n_nxt;
        end
    end

    // Stretched error pulse
    // Length is a parameter so that a slower clock can keep the span
    // between the least and the longest allowed width
    str_state_t           str_st_r;
    str_state_t           str_st_nxt;
    logic [STR_W-1:0]     str_cnt_r;
    logic [STR_W-1:0]     str_cnt_nxt;
    logic                 str_out_r;
    logic                 str_out_nxt;

    // Retriggerable, so a burst of errors reads as one long pulse
    always_comb begin
        str_st_nxt  = str_st_r;
        str_cnt_nxt = str_cnt_r;
        case (str_st_r)
            ST_IDLE: begin
                if (err_evt) begin
                    str_st_nxt  = ST_HOLD;
                    str_cnt_nxt = STR_W'(STRETCH_CYCLES - 1);
                end
            end
            ST_HOLD: begin
                if (err_evt) begin
                    str_cnt_nxt = STR_W'(STRETCH_CYCLES - 1);
                end else if (str_cnt_r == '0) begin
                    str_st_nxt = ST_IDLE;
                end else begin
                    str_cnt_nxt = str_cnt_r - STR_W'(1);
                end
            end
            default: begin
                str_st_nxt  = ST_IDLE;
                str_cnt_nxt = '0;
            end
        endcase
        str_out_nxt = (str_st_nxt == ST_HOLD);
    end

    // Output flop follows the next state, so it rises with the error
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            str_st_r  <= ST_IDLE;
            str_cnt_r <= '0;
            str_out_r <= 1'b0;
        end else begin
            str_st_r  <= str_st_nxt;
            str_cnt_r <= str_cnt_nxt;
            str_out_r <= str_out_nxt;
        end
    end

    // Pulse fail timers
    // Time based, since the line carries no framing to count against;
    // the limit is a parameter with a plain default
    logic [FAIL_W-1:0] pfail_cnt_r;
    logic [FAIL_W-1:0] pfail_cnt_nxt;
    logic [FAIL_W-1:0] nfail_cnt_r;
    logic [FAIL_W-1:0] nfail_cnt_nxt;
    logic              pfail_r;
    logic              pfail_nxt;
    logic              nfail_r;
    logic              nfail_nxt;

    // Any indication of a polarity, even a malformed one, proves it present
    always_comb begin
        pfail_cnt_nxt = fail_step(pfail_cnt_r, pos_end);
        nfail_cnt_nxt = fail_step(nfail_cnt_r, neg_end);
        pfail_nxt     = (pfail_cnt_nxt == FAIL_W'(FAIL_CYCLES));
        nfail_nxt     = (nfail_cnt_nxt == FAIL_W'(FAIL_CYCLES));
    end

    // Timers start from zero, so fails rise only after a full quiet span
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pfail_cnt_r <= '0;
            nfail_cnt_r <= '0;
            pfail_r     <= 1'b0;
            nfail_r     <= 1'b0;
        end else begin
            pfail_cnt_r <= pfail_cnt_nxt;
            nfail_cnt_r <= nfail_cnt_nxt;
            pfail_r     <= pfail_nxt;
            nfail_r     <= nfail_nxt;
        end
    end

    // Symbol rate check
    // For the faster variant the rated period rounds down to one clock,
    // so the check reduces to ends falling in the same cycle
    logic [GAP_W-1:0] gap_r;
    logic [GAP_W-1:0] gap_nxt;
    logic             rate_r;
    logic             rate_nxt;

    // Sampling cannot resolve symbols closer than the rated period, so
    // such events are reported rather than silently merged
    always_comb begin
        rate_nxt = any_sym && (32'(gap_r) < 32'(SYM_CYC - 1)) ||
                   (pos_end && neg_end);
        gap_nxt  = gap_r;
        if (any_sym) begin
            gap_nxt = '0;
        end else if (gap_r != '1) begin
            gap_nxt = gap_r + GAP_W'(1);
        end
    end

    // Gap starts saturated: the first symbol is never refused
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap_r  <= '1;
            rate_r <= 1'b0;
        end else begin
            gap_r  <= gap_nxt;
            rate_r <= rate_nxt;
        end
    end

    // Outputs straight from flip-flops
    // No logic after the registers keeps output timing clean
    assign err_fast_n  = fast_n_r;
    assign err_stretch = str_out_r;
    assign pos_fail    = pfail_r;
    assign neg_fail    = nfail_r;
    assign rate_err    = rate_r;
    assign dsum        = sr_r;
    assign dsum_valid  = valid_r;
endmodule

// *** verification/tcm_monitor_asserts.sv ***
// Concurrent checks on the ternary code error monitor ports
`timescale 1ns/100ps
module tcm_monitor_asserts
    import tcm_pkg::*;
#(
    parameter int FAIL_CYCLES    = FAIL_CYC,
    parameter int RATE_KBAUD     = RATE_FAST_KBAUD,
    parameter int STRETCH_CYCLES = STR_TYP_CYC
) (
    input wire logic       clk_sys,      // System clock
    input wire logic       rst_n,        // Async reset, active low
    input wire logic       pos_ind,      // Positive indication
    input wire logic       neg_ind,      // Negative indication
    input wire logic       err_fast_n,   // Fast error, active low
    input wire logic       err_stretch,  // Stretched error
    input wire logic       pos_fail,     // Positive pulses absent
    input wire logic       neg_fail,     // Negative pulses absent
    input wire logic       rate_err,     // Refused symbol pair
    input wire logic [4:0] dsum,         // Running-sum register
    input wire logic       dsum_valid    // Thermometer flag
);
    logic [7:0] since_err_r;    // Cycles since last fast error, saturating
    logic [7:0] since_err_nxt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Saturates at the stretch length so a long quiet spell never wraps
    always_comb begin
        since_err_nxt = since_err_r;
        if (!err_fast_n) since_err_nxt = 8'h01;
        else if (since_err_r < STRETCH_CYCLES) since_err_nxt = since_err_r + 8'h01;
    end

    // Starts saturated: no stretch is owed out of reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) since_err_r <= 8'(STRETCH_CYCLES);
        else since_err_r <= since_err_nxt;
    end

    sequence err_pulse_s;
        !err_fast_n ##1 err_fast_n;
    endsequence

    valid_flag_a: assert property (
        dsum_valid == (dsum inside {5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f}))
        else $error("thermometer flag disagrees with register");
    fast_width_a: assert property ($fell(err_fast_n) |-> err_pulse_s)
        else $error("fast error pulse longer than one cycle");
    stretch_start_a: assert property (!err_fast_n |-> err_stretch)
        else $error("stretched error missing at error");
    stretch_len_a: assert property (
        err_fast_n |-> err_stretch == (since_err_r < STRETCH_CYCLES))
        else $error("stretched error length wrong");
    shift_step_a: assert property (
        $changed(dsum) |-> dsum == 5'({$past(dsum), 1'b1}) || dsum == ($past(dsum) >> 1))
        else $error("register moved other than one step");
    err_saturated_a: assert property (
        !err_fast_n |-> $stable(dsum) && (dsum == 5'h1f || dsum == 5'h00))
        else $error("error with register not saturated");
    rate_refuse_a: assert property (rate_err |-> $stable(dsum) && err_fast_n)
        else $error("refused symbol changed state");
    pos_fail_clear_a: assert property (
        pos_fail |-> !($changed(dsum) && dsum == 5'({$past(dsum), 1'b1})))
        else $error("positive fail held across positive symbol");
    neg_fail_clear_a: assert property (
        neg_fail |-> !($changed(dsum) && dsum == ($past(dsum) >> 1)))
        else $error("negative fail held across negative symbol");
endmodule

bind tcm_monitor tcm_monitor_asserts #(
    .FAIL_CYCLES(FAIL_CYCLES), .RATE_KBAUD(RATE_KBAUD), .STRETCH_CYCLES(STRETCH_CYCLES)
) tcm_monitor_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .pos_ind(pos_ind), .neg_ind(neg_ind),
    .err_fast_n(err_fast_n), .err_stretch(err_stretch), .pos_fail(pos_fail),
    .neg_fail(neg_fail), .rate_err(rate_err), .dsum(dsum), .dsum_valid(dsum_valid)
);

// *** verification/tcm_line_src.sv ***
// Line source model: comparator indications for one ternary symbol per request
`timescale 1ns/100ps
module tcm_line_src (
    input  wire logic       clk_sys,  // Bench clock
    input  wire logic       go,       // Start one symbol
    input  wire logic [1:0] sym,      // 0 zero, 1 positive, 2 negative, 3 both
    input  wire logic [3:0] hold,     // Cycles the indication stays high
    output logic            pos_ind,  // Positive comparator level
    output logic            neg_ind,  // Negative comparator level
    output logic            busy      // Symbol in progress
);
    // Low gap after each symbol keeps spacing well inside the rated symbol rate
    initial begin
        pos_ind = 1'b0;
        neg_ind = 1'b0;
        busy    = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (go) begin
                busy = 1'b1;
                @(negedge clk_sys);
                pos_ind = sym[0];
                neg_ind = sym[1];
                repeat (hold) @(negedge clk_sys);
                pos_ind = 1'b0;
                neg_ind = 1'b0;
                repeat (3) @(negedge clk_sys);
                busy = 1'b0;
            end
        end
    end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the ternary code error monitor
`timescale 1ns/100ps
module tb_top;
    import tcm_pkg::*;
    localparam int FAIL = 20;
    localparam int STR  = 88;
    logic        clk_sys, rst_n, go, busy, pos_ind, neg_ind;
    logic        err_fast_n, err_stretch, pos_fail, neg_fail, rate_err, dsum_valid;
    logic [1:0]  sym;
    logic [3:0]  hold;
    logic [4:0]  dsum, exp_dsum, prev_dsum;
    logic [15:0] rnd;
    logic [6:0]  notes[$];
    logic [6:0]  want;
    int          failures, checks_done, n;

    tcm_line_src tcm_line_src_inst (.clk_sys(clk_sys), .go(go), .sym(sym), .hold(hold),
        .pos_ind(pos_ind), .neg_ind(neg_ind), .busy(busy));
    tcm_monitor #(.FAIL_CYCLES(FAIL), .STRETCH_CYCLES(STR)) tcm_monitor_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .pos_ind(pos_ind), .neg_ind(neg_ind),
        .err_fast_n(err_fast_n), .err_stretch(err_stretch), .pos_fail(pos_fail),
        .neg_fail(neg_fail), .rate_err(rate_err), .dsum(dsum), .dsum_valid(dsum_valid));

    function automatic logic [15:0] next_rnd(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction

    task automatic check(input string what, input logic [6:0] seen, input logic [6:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Notes the expected result, then asks the line model for the symbol
    task automatic send(input logic [1:0] s, input logic [3:0] h);
        logic err;
        err = (s == 2'd1) ? exp_dsum[4] : !exp_dsum[0];
        if (s == 2'd1 && !err) exp_dsum = {exp_dsum[3:0], 1'b1};
        if (s == 2'd2 && !err) exp_dsum = {1'b0, exp_dsum[4:1]};
        if (s == 2'd3) notes.push_back({exp_dsum, 2'b01});
        else if (s != 2'd0) notes.push_back({exp_dsum, err, 1'b0});
        @(negedge clk_sys);
        sym = s;
        hold = h;
        go = 1'b1;
        @(negedge clk_sys);
        go = 1'b0;
        for (int i = 0; i < 40 && busy; i++) @(negedge clk_sys);
        if (busy) begin
            failures++;
            close_out();
        end
    endtask

    // Free-running 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Result watcher: pairs each visible result with the oldest note
    initial begin
        prev_dsum = 5'h00;
        forever begin
            @(posedge clk_sys);
            #1;
            if (rst_n && (dsum !== prev_dsum || err_fast_n !== 1'b1 || rate_err !== 1'b0)) begin
                want = (notes.size() > 0) ? notes.pop_front() : 7'h7f;
                check("result", {dsum, !err_fast_n, rate_err}, want);
                check("dsum_valid", {6'h00, dsum_valid}, 7'h01);
            end
            prev_dsum = dsum;
        end
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        close_out();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        go = 1'b0;
        sym = 2'd0;
        hold = 4'd2;
        exp_dsum = 5'h00;
        rnd = 16'h003c;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        check("dsum_reset", {2'b00, dsum}, 7'h00);
        repeat (FAIL + 8) @(negedge clk_sys);
        check("fails_quiet", {5'h00, pos_fail, neg_fail}, 7'h03);
        send(2'd1, 4'd2);
        repeat (8) @(negedge clk_sys);
        check("fails_pos", {5'h00, pos_fail, neg_fail}, 7'h01);
        send(2'd2, 4'd3);
        repeat (8) @(negedge clk_sys);
        check("neg_fail", {6'h00, neg_fail}, 7'h00);
        $display("test fail_flags done");
        send(2'd2, 4'd3);
        for (int i = 0; i < 6; i++) send(2'd1, 4'(2 + i));
        // Earlier error may still hold the stretch; count from the last one
        for (int i = 0; i < 20 && err_fast_n !== 1'b0; i++) @(negedge clk_sys);
        n = 0;
        for (int i = 0; i < 400 && err_stretch === 1'b1; i++) begin
            n++;
            @(negedge clk_sys);
        end
        check("stretch_len", 7'(n), 7'(STR));
        $display("test fill_and_stretch done");
        for (int i = 0; i < 3; i++) send(2'd0, 4'd4);
        check("dsum_zero", {2'b00, dsum}, 7'h1f);
        for (int i = 0; i < 6; i++) send(2'd2, 4'(8 - i));
        send(2'd3, 4'd3);
        $display("test drain_and_refuse done");
        for (int i = 0; i < 40; i++) begin
            rnd = next_rnd(rnd);
            send(rnd[1:0], 4'd2 + {1'b0, rnd[4:2]});
        end
        repeat (12) @(negedge clk_sys);
        check("pending", 7'(notes.size()), 7'h00);
        $display("test random done");
        close_out();
    end
endmodule
